//--- ofsr_pkg.sv
// Constants shared by the output format and status register bank.
package ofsr_pkg;
   // Register indices; the AXI byte address of each register is four times its index.
   localparam logic [13:0] IDX_PAT4_LO = 14'h0557;
   localparam logic [13:0] IDX_PAT4_HI = 14'h0558;
   localparam logic [13:0] IDX_STSEL = 14'h0559;
   localparam logic [13:0] IDX_FORMAT = 14'h0561;
   localparam logic [13:0] IDX_OR_CLEAR = 14'h0562;
   localparam logic [13:0] IDX_OR_STATUS = 14'h0563;
   localparam logic [13:0] IDX_CHAN = 14'h0564;
   localparam logic [13:0] IDX_IRQ_STATUS = 14'h0570;
   localparam logic [13:0] IDX_IRQ_ENABLE = 14'h0571;
   localparam logic [13:0] IDX_IRQ_CLEAR = 14'h0572;
   // Bus widths.
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int SAMPLE_W = 14;
   localparam int NUM_VC = 8;
   localparam int NUM_CH = 2;
   // Field positions.
   localparam int FMT_SEL_LSB = 0;
   localparam int FMT_SEL_W = 2;
   localparam int INVERT_BIT = 2;
   localparam int SWAP_BIT = 0;
   localparam int STSEL_LSB = 0;
   localparam int STSEL_W = 3;
   // Reset values.
   localparam logic [7:0] PAT_RESET = 8'h00;
   localparam logic [STSEL_W-1:0] STSEL_RESET = 3'h0;
   localparam logic [FMT_SEL_W-1:0] FMT_SEL_RESET = 2'h1;
   localparam logic INVERT_RESET = 1'b0;
   localparam logic [7:0] OR_CLEAR_RESET = 8'h00;
   localparam logic [7:0] OR_STATUS_RESET = 8'h00;
   localparam logic SWAP_RESET = 1'b0;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // Number format codes.
   localparam logic [FMT_SEL_W-1:0] FMT_OFFSET = 2'h0;
   localparam logic [FMT_SEL_W-1:0] FMT_TWOS = 2'h1;
   localparam logic [SAMPLE_W-1:0] SIGN_MASK = 14'h2000;
   // Status bit selection codes.
   localparam logic [STSEL_W-1:0] ST_TIE_LOW = 3'h0;
   localparam logic [STSEL_W-1:0] ST_OVERRANGE = 3'h1;
   localparam logic [STSEL_W-1:0] ST_SIG_MON = 3'h2;
   localparam logic [STSEL_W-1:0] ST_FAST_VDR = 3'h3;
   localparam logic [STSEL_W-1:0] ST_VDR_RES = 3'h4;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ofsr_pkg

//--- ofsr_cfg_if.sv
// Format and status settings passed from the register bank to each channel formatter.
`timescale 1ns/10ps
interface ofsr_cfg_if;
   logic [ofsr_pkg::FMT_SEL_W-1:0] fmt_sel;
   logic invert;
   logic [ofsr_pkg::STSEL_W-1:0] status_sel;
   modport src (output fmt_sel, output invert, output status_sel);
   modport snk (input fmt_sel, input invert, input status_sel);
endinterface : ofsr_cfg_if

//--- ofsr_formatter.sv
// One output channel: number format, sample inversion and per-sample status bit.
`timescale 1ns/10ps
module ofsr_formatter (
   ofsr_cfg_if.snk cfg, // Shared settings.
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [ofsr_pkg::SAMPLE_W-1:0] sample_in, // Offset binary sample.
   input wire logic overrange_in, // Over-range bit of this sample.
   input wire logic sig_monitor_in, // Signal monitor bit.
   input wire logic fast_level_detect_in, // Fast level detect bit.
   input wire logic variable_range_flag_in, // Variable-range flag.
   input wire logic vdr_resolution_in, // Variable-range high/low resolution bit.
   output logic [ofsr_pkg::SAMPLE_W-1:0] sample_out, // Formatted sample.
   output logic status_out // Selected status bit.
);
   import ofsr_pkg::*;

   // ==========================================================
   // Formatting
   wire logic fmt_twos_w;
   wire logic [SAMPLE_W-1:0] coded_w;
   wire logic [SAMPLE_W-1:0] formatted_w;
   wire logic status_w;

   assign fmt_twos_w = (cfg.fmt_sel == FMT_TWOS); // RULE6
   assign coded_w = fmt_twos_w ? (sample_in ^ SIGN_MASK) : sample_in; // RULE6
   assign formatted_w = cfg.invert ? ~coded_w : coded_w; // RULE5

   // ==========================================================
   // Status bit selection
   // Unused codes tie the bit low.
   assign status_w = (cfg.status_sel == ST_OVERRANGE) ? overrange_in : // RULE7
                     (cfg.status_sel == ST_SIG_MON) ? sig_monitor_in : // RULE7
                     (cfg.status_sel == ST_FAST_VDR) ? (fast_level_detect_in | variable_range_flag_in) : // RULE8
                     (cfg.status_sel == ST_VDR_RES) ? vdr_resolution_in : // RULE8
                     1'b0; // RULE7

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_out <= '0;
         status_out <= 1'b0;
      end else begin
         sample_out <= formatted_w;
         status_out <= status_w;
      end
   end
endmodule : ofsr_formatter

//--- ofsr_regs.sv
// Output format and over-range status register bank with AXI4-Lite access.
`timescale 1ns/10ps
// What this block does
// RULE1: Each clear bit forces its virtual converter's over-range flag cleared while one.
// RULE2: Status holds one flag per converter, set when that converter over-ranges.
// RULE3: Over-range status is read-only, writes ignored, resets to zero.
// RULE4: Channel swap bit exchanges the two converter channels on the outputs.
// RULE5: Sample invert bit inverts every output sample when one.
// RULE6: Format select: 00 offset binary, 01 two's complement, reset 01.
// RULE7: Status select: 000 low, 001 over-range, 010 signal monitor.
// RULE8: Status select: 011 fast detect or range flag, 100 resolution bit; reset 000.
// RULE9: Fourth test pattern kept as low and high bytes, both reset to zero.
// RULE10: Flag held at zero while cleared, records new events after release.
module ofsr_regs (
   input wire logic aclk, // System clock, 40 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [ofsr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic [2:0] s_axi_awprot, // Write protection, unused.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [ofsr_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [ofsr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic [2:0] s_axi_arprot, // Read protection, unused.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [ofsr_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic [ofsr_pkg::SAMPLE_W-1:0] sample_a_in, // Converter channel A sample.
   input wire logic [ofsr_pkg::SAMPLE_W-1:0] sample_b_in, // Converter channel B sample.
   input wire logic [ofsr_pkg::NUM_CH-1:0] ch_overrange, // Per-sample over-range, bit 0 is A.
   input wire logic [ofsr_pkg::NUM_CH-1:0] sig_monitor, // Signal monitor bits.
   input wire logic [ofsr_pkg::NUM_CH-1:0] fast_level_detect, // Fast level detect bits.
   input wire logic [ofsr_pkg::NUM_CH-1:0] variable_range_flag, // Variable-range flags.
   input wire logic [ofsr_pkg::NUM_CH-1:0] vdr_resolution, // Variable-range resolution bits.
   input wire logic [ofsr_pkg::NUM_VC-1:0] vc_overrange, // Over-range event per virtual converter.
   output logic [ofsr_pkg::SAMPLE_W-1:0] sample_a_out, // Output lane A sample.
   output logic [ofsr_pkg::SAMPLE_W-1:0] sample_b_out, // Output lane B sample.
   output logic [ofsr_pkg::NUM_CH-1:0] status_bit_out, // Status bit per lane, bit 0 is A.
   output logic [15:0] test_pattern_word, // Fourth user test pattern.
   output logic irq // Level interrupt.
);
   import ofsr_pkg::*;

   // ==========================================================
   // Register state
   logic [7:0] pat_lo_r;
   logic [7:0] pat_hi_r;
   logic [STSEL_W-1:0] stsel_r;
   logic [FMT_SEL_W-1:0] fmt_sel_r;
   logic invert_r;
   logic [NUM_VC-1:0] or_clear_r;
   logic [NUM_VC-1:0] or_status_r;
   logic [NUM_VC-1:0] or_status_nxt;
   logic swap_r;
   logic [NUM_VC-1:0] irq_status_r;
   logic [NUM_VC-1:0] irq_status_nxt;
   logic [NUM_VC-1:0] irq_enable_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [DATA_W-1:0] rdata_r;
   logic irq_r;

   // ==========================================================
   // Write channel
   // Both ready flags rise together once address and data are offered, so the write lands in one edge.
   wire logic wr_en_w;
   wire logic [13:0] wr_idx_w;
   wire logic lane0_w;
   wire logic [7:0] wbyte_w;
   wire logic wr_hit_w;

   assign wr_en_w = s_axi_awvalid & awready_r & s_axi_wvalid & wready_r;
   assign wr_idx_w = s_axi_awaddr[ADDR_W-1:2];
   assign lane0_w = wr_en_w & s_axi_wstrb[0];
   assign wbyte_w = s_axi_wdata[7:0];
   assign wr_hit_w = (wr_idx_w == IDX_PAT4_LO) | (wr_idx_w == IDX_PAT4_HI) | (wr_idx_w == IDX_STSEL) |
                     (wr_idx_w == IDX_FORMAT) | (wr_idx_w == IDX_OR_CLEAR) | (wr_idx_w == IDX_OR_STATUS) |
                     (wr_idx_w == IDX_CHAN) | (wr_idx_w == IDX_IRQ_STATUS) | (wr_idx_w == IDX_IRQ_ENABLE) |
                     (wr_idx_w == IDX_IRQ_CLEAR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
      end else begin
         awready_r <= ~awready_r & s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
         wready_r <= ~wready_r & s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_en_w) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pat_lo_r <= PAT_RESET; // RULE9
         pat_hi_r <= PAT_RESET; // RULE9
         stsel_r <= STSEL_RESET; // RULE8
         fmt_sel_r <= FMT_SEL_RESET; // RULE6
         invert_r <= INVERT_RESET;
         or_clear_r <= OR_CLEAR_RESET;
         swap_r <= SWAP_RESET; // RULE4
         irq_enable_r <= IRQ_RESET;
      end else if (lane0_w) begin
         if (wr_idx_w == IDX_PAT4_LO) begin
            pat_lo_r <= wbyte_w; // RULE9
         end
         if (wr_idx_w == IDX_PAT4_HI) begin
            pat_hi_r <= wbyte_w; // RULE9
         end
         if (wr_idx_w == IDX_STSEL) begin
            stsel_r <= wbyte_w[STSEL_LSB +: STSEL_W]; // RULE7
         end
         if (wr_idx_w == IDX_FORMAT) begin
            fmt_sel_r <= wbyte_w[FMT_SEL_LSB +: FMT_SEL_W]; // RULE6
            invert_r <= wbyte_w[INVERT_BIT]; // RULE5
         end
         if (wr_idx_w == IDX_OR_CLEAR) begin
            or_clear_r <= wbyte_w; // RULE1
         end
         if (wr_idx_w == IDX_CHAN) begin
            swap_r <= wbyte_w[SWAP_BIT]; // RULE4
         end
         if (wr_idx_w == IDX_IRQ_ENABLE) begin
            irq_enable_r <= wbyte_w;
         end
      end
   end

   // ==========================================================
   // Over-range flags and interrupt
   // A held clear bit beats a simultaneous event; the interrupt sticky bit lets the event beat its clear.
   wire logic [NUM_VC-1:0] or_set_w;
   wire logic [NUM_VC-1:0] irq_clr_w;

   assign or_set_w = vc_overrange & ~or_clear_r; // RULE10
   assign irq_clr_w = (lane0_w && wr_idx_w == IDX_IRQ_CLEAR) ? wbyte_w : '0;

   always_comb begin
      or_status_nxt = (or_status_r | vc_overrange) & ~or_clear_r; // RULE1 RULE2 RULE3
      irq_status_nxt = (irq_status_r & ~irq_clr_w) | or_set_w;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         or_status_r <= OR_STATUS_RESET; // RULE3
         irq_status_r <= IRQ_RESET;
         irq_r <= 1'b0;
      end else begin
         or_status_r <= or_status_nxt; // RULE2
         irq_status_r <= irq_status_nxt;
         irq_r <= |(irq_status_r & irq_enable_r);
      end
   end

   // ==========================================================
   // Read channel
   wire logic rd_en_w;
   wire logic [13:0] rd_idx_w;
   wire logic rd_hit_w;
   wire logic [7:0] rd_byte_w;

   assign rd_en_w = s_axi_arvalid & arready_r;
   assign rd_idx_w = s_axi_araddr[ADDR_W-1:2];
   assign rd_hit_w = (rd_idx_w == IDX_PAT4_LO) | (rd_idx_w == IDX_PAT4_HI) | (rd_idx_w == IDX_STSEL) |
                     (rd_idx_w == IDX_FORMAT) | (rd_idx_w == IDX_OR_CLEAR) | (rd_idx_w == IDX_OR_STATUS) |
                     (rd_idx_w == IDX_CHAN) | (rd_idx_w == IDX_IRQ_STATUS) | (rd_idx_w == IDX_IRQ_ENABLE) |
                     (rd_idx_w == IDX_IRQ_CLEAR);
   // The interrupt clear register is write-only and reads as zero.
   assign rd_byte_w = (rd_idx_w == IDX_PAT4_LO) ? pat_lo_r :
                      (rd_idx_w == IDX_PAT4_HI) ? pat_hi_r :
                      (rd_idx_w == IDX_STSEL) ? {5'h00, stsel_r} :
                      (rd_idx_w == IDX_FORMAT) ? {5'h00, invert_r, fmt_sel_r} :
                      (rd_idx_w == IDX_OR_CLEAR) ? or_clear_r :
                      (rd_idx_w == IDX_OR_STATUS) ? or_status_r :
                      (rd_idx_w == IDX_CHAN) ? {7'h00, swap_r} :
                      (rd_idx_w == IDX_IRQ_STATUS) ? irq_status_r :
                      (rd_idx_w == IDX_IRQ_ENABLE) ? irq_enable_r :
                      8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
      end else begin
         arready_r <= ~arready_r & s_axi_arvalid & ~rvalid_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (rd_en_w) begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
         rdata_r <= {24'h00_0000, rd_byte_w};
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ==========================================================
   // Output data path
   wire logic [SAMPLE_W-1:0] lane_a_w;
   wire logic [SAMPLE_W-1:0] lane_b_w;
   wire logic [NUM_CH-1:0] ovr_w;
   wire logic [NUM_CH-1:0] mon_w;
   wire logic [NUM_CH-1:0] fld_w;
   wire logic [NUM_CH-1:0] vrf_w;
   wire logic [NUM_CH-1:0] res_w;

   assign lane_a_w = swap_r ? sample_b_in : sample_a_in; // RULE4
   assign lane_b_w = swap_r ? sample_a_in : sample_b_in; // RULE4
   assign ovr_w = swap_r ? {ch_overrange[0], ch_overrange[1]} : ch_overrange; // RULE4
   assign mon_w = swap_r ? {sig_monitor[0], sig_monitor[1]} : sig_monitor;
   assign fld_w = swap_r ? {fast_level_detect[0], fast_level_detect[1]} : fast_level_detect;
   assign vrf_w = swap_r ? {variable_range_flag[0], variable_range_flag[1]} : variable_range_flag;
   assign res_w = swap_r ? {vdr_resolution[0], vdr_resolution[1]} : vdr_resolution;

   ofsr_cfg_if cfg_bus ();
   assign cfg_bus.fmt_sel = fmt_sel_r;
   assign cfg_bus.invert = invert_r;
   assign cfg_bus.status_sel = stsel_r;

   ofsr_formatter u_fmt_a (
      .cfg(cfg_bus.snk),
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_in(lane_a_w),
      .overrange_in(ovr_w[0]),
      .sig_monitor_in(mon_w[0]),
      .fast_level_detect_in(fld_w[0]),
      .variable_range_flag_in(vrf_w[0]),
      .vdr_resolution_in(res_w[0]),
      .sample_out(sample_a_out),
      .status_out(status_bit_out[0])
   );

   ofsr_formatter u_fmt_b (
      .cfg(cfg_bus.snk),
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_in(lane_b_w),
      .overrange_in(ovr_w[1]),
      .sig_monitor_in(mon_w[1]),
      .fast_level_detect_in(fld_w[1]),
      .variable_range_flag_in(vrf_w[1]),
      .vdr_resolution_in(res_w[1]),
      .sample_out(sample_b_out),
      .status_out(status_bit_out[1])
   );

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign test_pattern_word = {pat_hi_r, pat_lo_r}; // RULE9
   assign irq = irq_r;

   // ==========================================================
   // Checks
   sequence wr_pat_lo_s;
      lane0_w && (wr_idx_w == IDX_PAT4_LO);
   endsequence

   sequence wr_status_quiet_s;
      lane0_w && (wr_idx_w == IDX_OR_STATUS) && (vc_overrange == 8'h00) && (or_clear_r == 8'h00);
   endsequence

   sequence plain_cfg_s;
      (fmt_sel_r == FMT_OFFSET) && !invert_r;
   endsequence

   or_clear_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1 RULE10
      (or_clear_r != 8'h00) |=> ((or_status_r & $past(or_clear_r)) == 8'h00))
      else $error("over-range flag not held clear");

   or_sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      (or_set_w != 8'h00) |=> ((or_status_r & $past(or_set_w)) == $past(or_set_w)))
      else $error("over-range event not recorded");

   or_status_ro_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
      wr_status_quiet_s |=> (or_status_r == $past(or_status_r)))
      else $error("over-range status changed by a write");

   chan_swap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      (plain_cfg_s and swap_r) |=> (sample_a_out == $past(sample_b_in)) && (sample_b_out == $past(sample_a_in)))
      else $error("channel swap not applied");

   sample_invert_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      ((fmt_sel_r == FMT_OFFSET) && invert_r && !swap_r) |=> (sample_a_out == ~$past(sample_a_in)))
      else $error("sample not inverted");

   twos_format_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
      ((fmt_sel_r == FMT_TWOS) && !invert_r && !swap_r) |=> ((sample_a_out ^ $past(sample_a_in)) == SIGN_MASK))
      else $error("two's complement coding wrong");

   status_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
      ((stsel_r == ST_OVERRANGE) && !swap_r) ##1 (stsel_r == ST_OVERRANGE) |->
      (status_bit_out == $past(ch_overrange)))
      else $error("status bit does not carry over-range");

   status_res_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
      ((stsel_r == ST_VDR_RES) && !swap_r) |=> (status_bit_out == $past(vdr_resolution)))
      else $error("status bit does not carry resolution bit");

   pattern_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
      wr_pat_lo_s |=> (test_pattern_word[7:0] == $past(wbyte_w)) && $stable(pat_hi_r))
      else $error("pattern low byte not stored");

   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_wvalid && !bvalid_r && !awready_r) |-> ##[1:2] bvalid_r)
      else $error("write response late");

   irq_set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (or_set_w != 8'h00) |=> ((irq_status_r & $past(or_set_w)) == $past(or_set_w)))
      else $error("interrupt status event lost");

   read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && !arready_r && !rvalid_r) |-> ##[1:2] rvalid_r)
      else $error("read response late");
endmodule : ofsr_regs

//--- ofsr_sink.sv
// Capture model of the downstream logic that takes the formatted output lanes.
`timescale 1ns/10ps
module ofsr_sink (
   input wire logic aclk, // Capture clock.
   input wire logic [ofsr_pkg::SAMPLE_W-1:0] lane_a, // Lane A sample.
   input wire logic [ofsr_pkg::SAMPLE_W-1:0] lane_b, // Lane B sample.
   input wire logic [ofsr_pkg::NUM_CH-1:0] lane_st, // Lane status bits.
   output logic [2*ofsr_pkg::SAMPLE_W+ofsr_pkg::NUM_CH-1:0] cap // Captured status, lane B, lane A.
);
   always_ff @(posedge aclk) begin
      cap <= {lane_st, lane_b, lane_a};
   end
endmodule : ofsr_sink

//--- output_format_status_regs_bench.sv
// Self-checking bench for the output format and over-range status register bank.
`timescale 1ns/10ps
module output_format_status_regs_bench;
   import ofsr_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 32'h0000_0000, rdata, r, seed = 32'h0000_9617;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, st_out, e;
   logic [13:0] sa = 14'h0000, sb = 14'h0000, oa, ob;
   logic [1:0] c_or = 0, c_sm = 0, c_fd = 0, c_vf = 0, c_vr = 0;
   logic [7:0] vc = 8'h00;
   logic [15:0] pat;
   logic [29:0] cap;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [29:0] lq[$];
   logic lchk = 1'b0;
   int fails = 0, n_checks = 0, cyc = 0;
   always #12.5 aclk = ~aclk;
   ofsr_regs u_ofsr_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sample_a_in(sa), .sample_b_in(sb), .ch_overrange(c_or), .sig_monitor(c_sm),
      .fast_level_detect(c_fd), .variable_range_flag(c_vf), .vdr_resolution(c_vr), .vc_overrange(vc),
      .sample_a_out(oa), .sample_b_out(ob), .status_bit_out(st_out), .test_pattern_word(pat), .irq(irq));
   ofsr_sink u_ofsr_sink (.aclk(aclk), .lane_a(oa), .lane_b(ob), .lane_st(st_out), .cap(cap));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [33:0] ok(input logic [7:0] v);
      return {RESP_OKAY, 24'h00_0000, v};
   endfunction : ok
   function automatic logic [13:0] fx(input logic [13:0] s, input logic [1:0] m);
      return (s ^ (m[0] ? SIGN_MASK : 14'h0000)) ^ {14{m[1]}};
   endfunction : fx
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t bus value %h expected %h", $time, got, exp);
      end
   endtask : chk
   // The capture holds the result two edges after the samples change; the watcher compares it one edge later.
   task automatic lane(input logic [29:0] exp);
      lq.push_back(exp);
      repeat (2) @(posedge aclk);
      lchk <= 1'b1;
      @(posedge aclk);
      lchk <= 1'b0;
   endtask : lane
   task automatic cmp_lane(input logic [29:0] got, input logic [29:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t lanes %h expected %h", $time, got, exp);
      end
   endtask : cmp_lane
   task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      logic ta, tw;
      ta = 0;
      tw = 0;
      bq.push_back(er);
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h00_0000, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (awready && !ta) begin
            awvalid <= 0;
            ta = 1;
         end
         if (wready && !tw) begin
            wvalid <= 0;
            tw = 1;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [13:0] idx, input logic [33:0] exp);
      rq.push_back(exp);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 0;
   endtask : rd
   task automatic pulse(input logic [7:0] v);
      @(posedge aclk);
      vc <= v;
      @(posedge aclk);
      vc <= 8'h00;
   endtask : pulse
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // The watcher pairs each bus answer with the oldest expectation noted by the driver.
   always @(posedge aclk) begin
      cyc++;
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) chk({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
      if (lchk) cmp_lane(cap, lq.pop_front());
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_PAT4_LO, ok(8'h00));
      rd(IDX_PAT4_HI, ok(8'h00));
      rd(IDX_STSEL, ok(8'h00));
      rd(IDX_FORMAT, ok(8'h01));
      rd(IDX_OR_CLEAR, ok(8'h00));
      rd(IDX_OR_STATUS, ok(8'h00));
      rd(IDX_CHAN, ok(8'h00));
      rd(14'h0001, {RESP_SLVERR, 32'h0000_0000});
      $display("test reset_values done");
      for (int m = 0; m < 8; m++) begin
         wr(IDX_FORMAT, {5'h00, m[1], 1'b0, m[0]});
         wr(IDX_CHAN, {7'h00, m[2]});
         @(posedge aclk);
         r = xs();
         sa <= r[13:0];
         sb <= r[29:16];
         if (m[2]) lane({2'b00, fx(r[13:0], m[1:0]), fx(r[29:16], m[1:0])});
         else lane({2'b00, fx(r[29:16], m[1:0]), fx(r[13:0], m[1:0])});
      end
      $display("test sample_format done");
      wr(IDX_CHAN, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(IDX_STSEL, c[7:0]);
         @(posedge aclk);
         r = xs();
         {c_or, c_sm, c_fd, c_vf, c_vr} <= r[9:0];
         e = (c == 1) ? r[9:8] : (c == 2) ? r[7:6] : (c == 3) ? (r[5:4] | r[3:2]) : (c == 4) ? r[1:0] : 2'b00;
         lane({e, fx(sb, 2'b11), fx(sa, 2'b11)});
      end
      $display("test status_select done");
      wr(IDX_IRQ_ENABLE, 8'h01);
      pulse(8'hA5);
      rd(IDX_OR_STATUS, ok(8'hA5));
      chk(ok({7'h00, irq}), ok(8'h01));
      wr(IDX_OR_STATUS, 8'hFF);
      rd(IDX_OR_STATUS, ok(8'hA5));
      wr(IDX_IRQ_CLEAR, 8'hFF);
      repeat (2) @(posedge aclk);
      chk(ok({7'h00, irq}), ok(8'h00));
      wr(IDX_OR_CLEAR, 8'hFF);
      rd(IDX_OR_STATUS, ok(8'h00));
      pulse(8'hFF);
      rd(IDX_OR_STATUS, ok(8'h00));
      wr(IDX_OR_CLEAR, 8'h0F);
      pulse(8'hFF);
      rd(IDX_OR_STATUS, ok(8'hF0));
      rd(IDX_IRQ_STATUS, ok(8'hF0));
      rd(IDX_IRQ_ENABLE, ok(8'h01));
      rd(IDX_IRQ_CLEAR, ok(8'h00));
      $display("test overrange done");
      wr(IDX_PAT4_LO, 8'h5A);
      wr(IDX_PAT4_HI, 8'hC3);
      rd(IDX_PAT4_LO, ok(8'h5A));
      rd(IDX_PAT4_HI, ok(8'hC3));
      chk({18'h0_0000, pat}, {18'h0_0000, 16'hC35A});
      wr(14'h0001, 8'h77, RESP_SLVERR);
      $display("test pattern done");
      tally_and_finish();
   end
endmodule : output_format_status_regs_bench
